// ---- verilog/tds_drop_status_regs.sv ----
// drop bus receive status and monitor registers with axi4-lite slave
// Notes on behaviour
// - v5 bit 8 sets remote defect flag
// - v5 bit 4 sets remote failure flag
// - flags clear on read, relatch if present
// - label field refreshed each v5 byte
// - label mismatch raised when labels differ
// - positive justification counter in bits 7-4
// - negative justification counter in bits 3-0
// - increment during read held, applied afterwards
// - counters clear on reset, control bit, read
// - overhead bits from both justification bytes
// - selector 1..28 picks tributary columns
// - column 1 is path overhead, excluded
// - columns 30 and 59 are fixed stuff
// - sts-3 handled as three sts-1 signals
`timescale 1ns/1ps
`include "tds_reg_map.svh"
module tds_drop_status_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire tds_pkg::tds_drop_bus_t drop,
  input wire logic [`TDS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`TDS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [7:0] tribData,
  output logic tribValid,
  output logic labelMismatch
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic remote_defect_flag_q, remote_failure_flag_q;
  logic rdiActive_q, rfiActive_q;
  logic [2:0] received_label_field_q, expected_label_field_q;
  logic [3:0] positive_just_counter_q, negative_just_counter_q;
  logic posPend_q, negPend_q;
  logic [7:0] received_overhead_bits_q;
  logic counter_clear_control_q, sts3Mode_q;
  logic [1:0] constSel_q;
  logic [6:0] tribSel_q;
  logic [7:0] tribData_q;
  logic tribValid_q, labelMismatch_q;

  // write path: address and data are taken together in one handshake
  wire wrTake = awvalid && wvalid && !awready_q && !bvalid_q;
  wire wrFire = awready_q && awvalid && wready_q && wvalid;
  wire [7:0] wIdx = awaddr[`TDS_ADDR_W-1:2];
  wire wLane0 = wstrb[0];
  wire wHitCtrl = wIdx == `TDS_IDX_CTRL;
  wire wHitLbl = wIdx == `TDS_IDX_EXPLBL;
  wire wHitTrib = wIdx == `TDS_IDX_TRIB;
  wire wMapped = wHitCtrl || wHitLbl || wHitTrib || wIdx == `TDS_IDX_ALARM
                 || wIdx == `TDS_IDX_JUST || wIdx == `TDS_IDX_OBITS;
  wire wrLbl = wrFire && wHitLbl && wLane0;
  wire wrCtrl = wrFire && wHitCtrl && wLane0;
  wire wrTrib = wrFire && wHitTrib && wLane0;

  // read path
  tds_pkg::tds_rd_state_t rdState_q, rdState_d;
  wire rdFire = arready_q && arvalid;
  wire [7:0] rIdx = araddr[`TDS_ADDR_W-1:2];
  wire rdAlarm = rdFire && rIdx == `TDS_IDX_ALARM;
  wire rdJust = rdFire && rIdx == `TDS_IDX_JUST;
  wire rMapped = rIdx == `TDS_IDX_ALARM || rIdx == `TDS_IDX_JUST ||
                 rIdx == `TDS_IDX_OBITS || rIdx == `TDS_IDX_EXPLBL ||
                 rIdx == `TDS_IDX_CTRL || rIdx == `TDS_IDX_TRIB;
  wire [7:0] alarmVal = {3'h0, remote_defect_flag_q, remote_failure_flag_q,
                         received_label_field_q};
  wire [7:0] justVal = {positive_just_counter_q, negative_just_counter_q};
  wire [7:0] ctrlVal = {4'h0, constSel_q, sts3Mode_q, 1'b0};
  wire [7:0] rSel =
    rIdx == `TDS_IDX_ALARM ? alarmVal :
    rIdx == `TDS_IDX_JUST ? justVal :
    rIdx == `TDS_IDX_OBITS ? received_overhead_bits_q :
    rIdx == `TDS_IDX_EXPLBL ? {5'h0, expected_label_field_q} :
    rIdx == `TDS_IDX_CTRL ? ctrlVal :
    rIdx == `TDS_IDX_TRIB ? {1'b0, tribSel_q} : 8'h00;

  always_comb begin
    rdState_d = rdState_q;
    unique case (rdState_q)
      tds_pkg::TDS_RD_IDLE: if (arvalid) rdState_d = tds_pkg::TDS_RD_ACK;
      tds_pkg::TDS_RD_ACK: rdState_d = tds_pkg::TDS_RD_RESP;
      tds_pkg::TDS_RD_RESP: if (rready) rdState_d = tds_pkg::TDS_RD_IDLE;
      default: rdState_d = tds_pkg::TDS_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdState_q <= tds_pkg::TDS_RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `TDS_RESP_OK;
    end else begin
      rdState_q <= rdState_d;
      arready_q <= rdState_q == tds_pkg::TDS_RD_IDLE && arvalid;
      if (rdFire) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h0, rSel};
        rresp_q <= rMapped ? `TDS_RESP_OK : `TDS_RESP_ERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `TDS_RESP_OK;
    end else begin
      awready_q <= wrTake;
      wready_q <= wrTake;
      if (wrFire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wMapped ? `TDS_RESP_OK : `TDS_RESP_ERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control registers; the clear bit is a one-cycle strobe, reads back 0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expected_label_field_q <= 3'h0;
      counter_clear_control_q <= 1'b0;
      sts3Mode_q <= 1'b0;
      constSel_q <= 2'h0;
      tribSel_q <= 7'h0;
    end else begin
      if (wrLbl) expected_label_field_q <= wdata[2:0];
      counter_clear_control_q <= wrCtrl && wdata[`TDS_CTRL_CLR];
      if (wrCtrl) begin
        sts3Mode_q <= wdata[`TDS_CTRL_STS3];
        constSel_q <= wdata[`TDS_CTRL_CONST_HI:`TDS_CTRL_CONST_LO];
      end
      if (wrTrib) tribSel_q <= wdata[6:0];
    end
  end

  // v5 monitoring; active levels persist between v5 bytes so flags relatch
  wire rdiNow = drop.v5Stb ? drop.data[`TDS_V5_RDI] : rdiActive_q;
  wire rfiNow = drop.v5Stb ? drop.data[`TDS_V5_RFI] : rfiActive_q;
  wire [2:0] v5Label = {drop.data[`TDS_V5_L7], drop.data[`TDS_V5_L6],
                        drop.data[`TDS_V5_L5]};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdiActive_q <= 1'b0;
      rfiActive_q <= 1'b0;
      remote_defect_flag_q <= 1'b0;
      remote_failure_flag_q <= 1'b0;
      received_label_field_q <= 3'h0;
      labelMismatch_q <= 1'b0;
    end else begin
      rdiActive_q <= rdiNow;
      rfiActive_q <= rfiNow;
      // set wins over the read clear
      remote_defect_flag_q <= rdiNow | (remote_defect_flag_q & ~rdAlarm);
      remote_failure_flag_q <= rfiNow | (remote_failure_flag_q & ~rdAlarm);
      if (drop.v5Stb) received_label_field_q <= v5Label;
      labelMismatch_q <= received_label_field_q != expected_label_field_q;
    end
  end

  // justification counters wrap at 4 bits; a read clears and defers one count
  wire clrCnt = counter_clear_control_q;
  wire [3:0] posInc = {3'h0, posPend_q} + {3'h0, drop.posJust};
  wire [3:0] negInc = {3'h0, negPend_q} + {3'h0, drop.negJust};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      positive_just_counter_q <= 4'h0;
      negative_just_counter_q <= 4'h0;
      posPend_q <= 1'b0;
      negPend_q <= 1'b0;
    end else if (clrCnt) begin
      positive_just_counter_q <= 4'h0;
      negative_just_counter_q <= 4'h0;
      posPend_q <= 1'b0;
      negPend_q <= 1'b0;
    end else if (rdJust) begin
      positive_just_counter_q <= 4'h0;
      negative_just_counter_q <= 4'h0;
      posPend_q <= drop.posJust;
      negPend_q <= drop.negJust;
    end else begin
      positive_just_counter_q <= positive_just_counter_q + posInc;
      negative_just_counter_q <= negative_just_counter_q + negInc;
      posPend_q <= 1'b0;
      negPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      received_overhead_bits_q <= 8'h0;
    end else begin
      if (drop.jc1Stb) received_overhead_bits_q[3:0] <= drop.data[`TDS_JC_HI:`TDS_JC_LO];
      if (drop.jc2Stb) received_overhead_bits_q[7:4] <= drop.data[`TDS_JC_HI:`TDS_JC_LO];
    end
  end

  // column decode; in sts-3 the bytes interleave over three sts-1 signals
  wire [8:0] colZ = drop.col - 9'h001;
  wire [8:0] colDiv = colZ / 9'h003;
  wire [8:0] colMod = colZ % 9'h003;
  wire [6:0] stsCol = sts3Mode_q ? colDiv[6:0] + 7'h01 : drop.col[6:0];
  wire constOk = !sts3Mode_q || colMod[1:0] == constSel_q;
  wire isPoh = stsCol == `TDS_COL_POH;
  wire isStuff = stsCol == `TDS_COL_STUFF1 || stsCol == `TDS_COL_STUFF2;
  wire selOk = tribSel_q != 7'h00 && tribSel_q <= `TDS_TRIB_MAX;
  wire colHit = stsCol == tribSel_q + `TDS_OFS_A || stsCol == tribSel_q + `TDS_OFS_B ||
                stsCol == tribSel_q + `TDS_OFS_C;
  wire tribHit = drop.colValid && constOk && selOk && colHit && !isPoh && !isStuff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tribValid_q <= 1'b0;
      tribData_q <= 8'h0;
    end else begin
      tribValid_q <= tribHit;
      if (tribHit) tribData_q <= drop.data;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign tribData = tribData_q;
  assign tribValid = tribValid_q;
  assign labelMismatch = labelMismatch_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rdJustPend;
    rdJust && drop.posJust && !clrCnt;
  endsequence
  sequence s_afterRead;
    ##1 !clrCnt ##1 positive_just_counter_q == 4'h1;
  endsequence
  a_rdi_flag_set: assert property (drop.v5Stb && drop.data[`TDS_V5_RDI]
    |=> remote_defect_flag_q) else $error("defect flag not set");
  a_rfi_flag_set: assert property (drop.v5Stb && drop.data[`TDS_V5_RFI]
    |=> remote_failure_flag_q) else $error("failure flag not set");
  a_flag_read_clear: assert property (rdAlarm && !rdiNow
    |=> !remote_defect_flag_q) else $error("flag not cleared by read");
  a_label_capture: assert property (drop.v5Stb
    |=> received_label_field_q == $past(v5Label)) else $error("label not captured");
  a_label_mismatch: assert property (received_label_field_q != expected_label_field_q
    |=> labelMismatch_q) else $error("mismatch missed");
  a_pos_count_inc: assert property (drop.posJust && !posPend_q && !rdJust && !clrCnt
    |=> positive_just_counter_q == $past(positive_just_counter_q) + 4'h1)
    else $error("positive count wrong");
  a_neg_count_inc: assert property (drop.negJust && !negPend_q && !rdJust && !clrCnt
    |=> negative_just_counter_q == $past(negative_just_counter_q) + 4'h1)
    else $error("negative count wrong");
  a_held_increment: assert property (s_rdJustPend |=> posPend_q)
    else $error("held increment lost");
  a_neg_held: assert property (rdJust && drop.negJust && !clrCnt |=> negPend_q)
    else $error("held negative increment lost");
  a_read_clear_cnt: assert property (rdJust && !clrCnt && !drop.posJust && !drop.negJust
    |=> positive_just_counter_q == 4'h0 && negative_just_counter_q == 4'h0)
    else $error("counters not cleared by read");
  a_pos_count_hold: assert property (!drop.posJust && !posPend_q && !rdJust && !clrCnt
    |=> $stable(positive_just_counter_q)) else $error("positive count moved");
  a_neg_count_hold: assert property (!drop.negJust && !negPend_q && !rdJust && !clrCnt
    |=> $stable(negative_just_counter_q)) else $error("negative count moved");
  a_rfi_read_clear: assert property (rdAlarm && !rfiNow
    |=> !remote_failure_flag_q) else $error("failure flag not cleared by read");
  a_rdi_relatch: assert property (rdAlarm && rdiNow
    |=> remote_defect_flag_q) else $error("defect flag did not relatch");
  a_label_hold: assert property (!drop.v5Stb
    |=> $stable(received_label_field_q)) else $error("label changed without v5");
  a_label_match: assert property (received_label_field_q == expected_label_field_q
    |=> !labelMismatch_q) else $error("false label mismatch");
  a_obits_jc2: assert property (drop.jc2Stb |=> received_overhead_bits_q[7:4] ==
    $past(drop.data[`TDS_JC_HI:`TDS_JC_LO])) else $error("second overhead bits wrong");
  a_obits_hold: assert property (!drop.jc1Stb && !drop.jc2Stb
    |=> $stable(received_overhead_bits_q)) else $error("overhead bits changed");
  a_explbl_write: assert property (wrLbl
    |=> expected_label_field_q == $past(wdata[2:0])) else $error("expected label not stored");
  a_trib_none: assert property (!tribHit |=> !tribValid_q)
    else $error("tributary byte without a hit");
  a_unsel_quiet: assert property (tribSel_q == 7'h00 |=> !tribValid_q)
    else $error("byte passed with no tributary selected");
  a_other_const: assert property (drop.colValid && sts3Mode_q &&
    colMod[1:0] != constSel_q |=> !tribValid_q) else $error("wrong constituent passed");
  // software must see a refused access, not a silent success
  a_wr_slverr: assert property (wrFire && !wMapped |=> bresp_q == `TDS_RESP_ERR)
    else $error("unmapped write not refused");
  a_rd_slverr: assert property (rdFire && !rMapped |=> rresp_q == `TDS_RESP_ERR)
    else $error("unmapped read not refused");
  a_held_applied: assert property (s_rdJustPend ##1 (!drop.posJust && !rdJust)
    |-> ##0 !clrCnt |=> positive_just_counter_q == 4'h1)
    else $error("held increment not applied");
  a_ctrl_clear: assert property (clrCnt |=> positive_just_counter_q == 4'h0 &&
    negative_just_counter_q == 4'h0) else $error("counters not cleared");
  a_obits_jc1: assert property (drop.jc1Stb |=> received_overhead_bits_q[3:0] ==
    $past(drop.data[`TDS_JC_HI:`TDS_JC_LO])) else $error("overhead bits wrong");
  a_poh_excluded: assert property (drop.colValid && isPoh |=> !tribValid_q)
    else $error("overhead column passed");
  a_stuff_excluded: assert property (drop.colValid && isStuff |=> !tribValid_q)
    else $error("stuff column passed");
  a_trib_select: assert property (tribHit |=> tribValid_q && tribData_q == $past(drop.data))
    else $error("tributary byte missed");
  a_explbl_stable: assert property (!wrLbl |=> $stable(expected_label_field_q))
    else $error("expected label changed");
endmodule

// ---- include/tds_reg_map.svh ----
// register map, field positions and fixed numbers of the drop status block
`ifndef TDS_REG_MAP_SVH
`define TDS_REG_MAP_SVH
`define TDS_IDX_ALARM 8'h3b
`define TDS_IDX_JUST 8'h3c
`define TDS_IDX_OBITS 8'h3d
`define TDS_IDX_EXPLBL 8'h3e
`define TDS_IDX_CTRL 8'h3f
`define TDS_IDX_TRIB 8'h40
`define TDS_ADDR_W 10
`define TDS_BIT_RDI 4
`define TDS_BIT_RFI 3
`define TDS_V5_RDI 0
`define TDS_V5_RFI 4
`define TDS_V5_L7 1
`define TDS_V5_L6 2
`define TDS_V5_L5 3
`define TDS_JC_HI 5
`define TDS_JC_LO 2
`define TDS_CTRL_CLR 0
`define TDS_CTRL_STS3 1
`define TDS_CTRL_CONST_HI 3
`define TDS_CTRL_CONST_LO 2
`define TDS_RESP_OK 2'h0
`define TDS_RESP_ERR 2'h2
`define TDS_COL_POH 7'h01
`define TDS_COL_STUFF1 7'h1e
`define TDS_COL_STUFF2 7'h3b
`define TDS_TRIB_MAX 7'h1c
`define TDS_OFS_A 7'h01
`define TDS_OFS_B 7'h1e
`define TDS_OFS_C 7'h3b
`endif

// ---- include/tds_pkg.sv ----
// types shared by the drop status block
package tds_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic v5Stb;
    logic jc1Stb;
    logic jc2Stb;
    logic posJust;
    logic negJust;
    logic colValid;
    logic [8:0] col;
  } tds_drop_bus_t;
  typedef enum logic [1:0] {
    TDS_RD_IDLE = 2'b00,
    TDS_RD_ACK = 2'b01,
    TDS_RD_RESP = 2'b10
  } tds_rd_state_t;
endpackage

// ---- verif/tds_drop_src.sv ----
// drop bus source that stands in for the overhead terminator
`timescale 1ns/1ps
module tds_drop_src (
  input wire logic clk,
  output tds_pkg::tds_drop_bus_t drop
);
  initial drop = '0;
  // s packs v5Stb, jc1Stb, jc2Stb, posJust, negJust, colValid in struct order
  task automatic send(input logic [5:0] s, input logic [8:0] c, input logic [7:0] d);
    @(posedge clk);
    drop <= {d, s, c};
    @(posedge clk);
    // released byte lane shows the inverse so a stale copy cannot pass
    drop <= {~d, 6'h00, c};
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the drop status registers
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [7:0] v5; logic [7:0] alarm; logic mis;} tds_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  tds_pkg::tds_drop_bus_t drop;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tribValid, labelMismatch;
  logic [1:0] bresp, rresp, br, rr;
  logic [31:0] rdata, rd;
  logic [7:0] tribData;
  int fail_count = 0;
  int n_compared = 0;
  tds_row_t rows [6] = '{'{8'h0a, 8'h05, 1'b0}, '{8'h01, 8'h10, 1'b1}, '{8'h10, 8'h08, 1'b1},
    '{8'h0f, 8'h17, 1'b1}, '{8'h1b, 8'h1d, 1'b0}, '{8'h04, 8'h02, 1'b1}};
  always #12.5 clk = ~clk;
  tds_drop_src tds_drop_src_i (.clk(clk), .drop(drop));
  tds_drop_status_regs tds_drop_status_regs_i (.clk(clk), .rstn(rstn), .drop(drop),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tribData(tribData), .tribValid(tribValid),
    .labelMismatch(labelMismatch));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [9:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // drive one payload byte and look at the tributary output once it has landed
  task automatic colchk(input logic [8:0] c, input logic [7:0] d, input logic v);
    tds_drop_src_i.send(6'h01, c, d);
    #1;
    chk(32'(tribValid), 32'(v));
    if (v) chk(32'(tribData), 32'(d));
  endtask
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'({bvalid, rvalid, tribValid}), 32'h0);
    axw(10'h0f8, 32'h5);
    chk(32'(br), 32'h0);
    axr(10'h0f8);
    chk(rd, 32'h5);
    chk(32'(rr), 32'h0);
    foreach (rows[i]) begin
      tds_drop_src_i.send(6'h20, 9'h0, rows[i].v5);
      repeat (2) @(posedge clk);
      #1;
      chk(32'(labelMismatch), 32'(rows[i].mis));
      // first read clears what earlier bytes latched, second shows the relatched state
      axr(10'h0ec);
      axr(10'h0ec);
      chk(rd, 32'(rows[i].alarm));
    end
    $display("alarm and label test done");
    axr(10'h0f0);
    repeat (3) tds_drop_src_i.send(6'h04, 9'h0, 8'h00);
    repeat (2) tds_drop_src_i.send(6'h02, 9'h0, 8'h00);
    axr(10'h0f0);
    chk(rd, 32'h32);
    tds_drop_src_i.send(6'h02, 9'h0, 8'h00);
    fork
      axr(10'h0f0);
      begin
        @(posedge clk);
        tds_drop_src_i.send(6'h04, 9'h0, 8'h00);
      end
    join
    chk(rd, 32'h01);
    axr(10'h0f0);
    chk(rd, 32'h10);
    tds_drop_src_i.send(6'h02, 9'h0, 8'h00);
    axw(10'h0fc, 32'h1);
    axr(10'h0f0);
    chk(rd, 32'h0);
    tds_drop_src_i.send(6'h04, 9'h0, 8'h00);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    axr(10'h0f0);
    chk(rd, 32'h0);
    $display("justification counter test done");
    tds_drop_src_i.send(6'h10, 9'h0, 8'h24);
    tds_drop_src_i.send(6'h08, 9'h0, 8'h0c);
    axr(10'h0f4);
    chk(rd, 32'h39);
    axr(10'h200);
    chk(32'(rr), 32'h2);
    axw(10'h200, 32'h1);
    chk(32'(br), 32'h2);
    $display("overhead and unmapped test done");
    for (int t = 1; t <= 28; t += 27) begin
      axw(10'h100, 32'(t));
      for (int k = 0; k < 3; k++) colchk(9'(t + 1 + 29 * k), 8'(8'h5a + k), 1'b1);
    end
    colchk(9'd1, 8'h11, 1'b0);
    colchk(9'd30, 8'h22, 1'b0);
    colchk(9'd59, 8'h33, 1'b0);
    axw(10'h100, 32'h0);
    colchk(9'd2, 8'h44, 1'b0);
    // constituent 1, tributary 1: sts-1 column 2 sits at interleaved column 5
    axw(10'h0fc, 32'h6);
    axw(10'h100, 32'h1);
    colchk(9'd5, 8'hc3, 1'b1);
    colchk(9'd4, 8'h3c, 1'b0);
    $display("tributary select test done");
    summarize();
  end
endmodule
